// [low_power_wakeup_cfg.svh]
`ifndef LOW_POWER_WAKEUP_CFG_SVH
`define LOW_POWER_WAKEUP_CFG_SVH
// register indices, byte address is four times the index
`define IDX_WAKE1 6'h00
`define IDX_WAKE2 6'h01
`define IDX_WAKE3 6'h02
`define IDX_WAKE4 6'h03
`define IDX_CTRL 6'h04
`define IDX_STAT 6'h05
`define WAKE_RST 8'h00
`define CTRL_RST 8'h00
// fourth enable register implemented bits per variant
`define WAKE4_FULL_MASK 8'h7F
`define WAKE4_SMALL_MASK 8'h01
// wakeup enable bit positions in the fourth register
`define W4_CIPHER 6
`define W4_T5CAP 5
`define W4_T5UPD 4
`define W4_SER3 3
`define W4_SER2 2
`define W4_SYNC2 1
`define W4_CAL 0
// control bits
`define CTL_REGULATOR_OFF_BIT 0
`define CTL_MEMPD 1
`define CTL_FASTHALT 2
`define CTL_FASTWAKE 3
`define CTL_ACTLVL 4
`define CTL_ACTHALT 5
// status bits, mode sits in bits 2:0
`define ST_REGRDY 3
`define ST_MEMRDY 4
`define ST_DISPBLK 5
`define ST_FASTDIV8 6
`define DISP_SYNC_CYCLES 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [low_power_wakeup_pkg.sv]
package low_power_wakeup_pkg;
  typedef enum logic [2:0] {
    MODE_RUN       = 3'b000,
    MODE_LP_RUN    = 3'b001,
    MODE_LP_WAIT   = 3'b010,
    MODE_HALT_PEND = 3'b011,
    MODE_HALT      = 3'b100,
    MODE_ACT_HALT  = 3'b101
  } lp_mode_e;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;
  typedef struct packed {
    logic [7:0] grp1;
    logic [7:0] grp2;
    logic [7:0] grp3;
    logic       cipher;
    logic       t5Capture;
    logic       t5Compare;
    logic       t5Update;
    logic       t5Trigger;
    logic       t5Break;
    logic       ser3Rx;
    logic       ser3Tx;
    logic       ser2Rx;
    logic       ser2Tx;
    logic       sync2Rx;
    logic       sync2Tx;
    logic       calendar;
    logic       clockFail;
  } wake_src_s;
  typedef struct packed {
    logic clkSwitch;
    logic memory;
    logic calSwitch;
    logic beepSwitch;
    logic beepActHalt;
  } halt_busy_s;
endpackage

// [low_power_wakeup_control.sv]
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "low_power_wakeup_cfg.svh"
// Functional notes
// [R1] bit 6 gates cipher interrupt wakeup
// [R2] bit 5 gates timer5 capture/compare wakeup
// [R3] bit 4 gates timer5 update/trigger/break wakeup
// [R4] bit 3 gates serial port 3 wakeup
// [R5] bit 2 gates serial port 2 wakeup
// [R6] bit 1 gates sync serial 2 wakeup
// [R7] bit 0 gates calendar or clock-fail wakeup
// [R8] four byte enables, reset zero, variant bits
// [R9] software orders low-power run entry
// [R10] clear regulator-off, regulator ready flag follows
// [R11] clear memory powerdown, memory ready flag follows
// [R12] wait instruction in low-power run waits event
// [R13] halt stops clocks except listed exceptions
// [R14] halt ignored while peripheral interrupt pending
// [R15] busy flags hold off halt entry
// [R16] fast-halt bit forces regulator off
// [R17] pin interrupts wake from halt
// [R18] fast-wakeup bit selects restart clock
// [R19] activation level returns straight to halt
// [R20] display access blocked two calendar cycles
// [R21] active-halt keeps only slow oscillator
// [R22] avoid halt from low-power run; halt is still accepted from MODE_LP_RUN
// [R23] wakeup is OR of enabled sources
module low_power_wakeup_control #(
  parameter logic [7:0] WAKE4_MASK = `WAKE4_FULL_MASK
) (
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire low_power_wakeup_pkg::axil_req_s axiReq,
  output low_power_wakeup_pkg::axil_rsp_s      axiRsp,
  input  wire low_power_wakeup_pkg::wake_src_s wakeSrc,
  input  wire low_power_wakeup_pkg::halt_busy_s haltBusy,
  input  wire logic                           waitEvtInstr,
  input  wire logic                           haltInstr,
  input  wire logic                           intReturn,
  input  wire logic                           periphIrqPending,
  input  wire logic                           extEvent,
  input  wire logic                           haltWakePin,
  input  wire logic                           haltWakeAlt,
  input  wire logic                           mainRegReadyIn,
  input  wire logic                           memReadyIn,
  input  wire logic                           debugUsesFastOsc,
  input  wire logic                           debugUsesSlowOsc,
  input  wire logic                           watchdogUsesSlowOsc,
  input  wire logic                           memWriteActive,
  input  wire logic                           calendarClk,
  output logic                                wakeEvent,
  output logic                                haltIgnored,
  output logic                                skipContextRestore,
  output logic [2:0]                          mode,
  output logic                                sysClkRun,
  output logic                                fastOscRun,
  output logic                                slowOscRun,
  output logic                                mainRegOn,
  output logic                                memPowerDown,
  output logic                                regReadyFlag,
  output logic                                memReadyFlag,
  output logic                                restartFastDiv8,
  output logic                                displayBlock
);

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  wakeEn_reg [4];
  logic [7:0]  ctrl_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  low_power_wakeup_pkg::lp_mode_e mode_reg;
  low_power_wakeup_pkg::lp_mode_e mode_next;
  logic        wake_reg;
  logic        ignored_reg;
  logic        skipCtx_reg;
  logic        fastDiv8_reg;
  logic        dispBlk_reg;
  logic [1:0]  dispCnt_reg;
  logic        calPrev_reg;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  logic [5:0]  awIdx;
  logic [5:0]  arIdx;
  logic        wrFire;
  logic        rdFire;
  logic        wrMapped;
  logic        rdMapped;
  logic        wrByte;
  logic [7:0]  wrData;
  logic [7:0]  statByte;
  logic [7:0]  rdByte;

  assign awIdx    = axiReq.awaddr[7:2];
  assign arIdx    = axiReq.araddr[7:2];
  assign wrFire   = axiReq.awvalid & axiReq.wvalid & ~bvalid_reg;
  assign rdFire   = axiReq.arvalid & ~rvalid_reg;
  assign wrMapped = (axiReq.awaddr[1:0] == 2'h0) &&
                    (awIdx <= `IDX_STAT);
  assign rdMapped = (axiReq.araddr[1:0] == 2'h0) &&
                    (arIdx <= `IDX_STAT);
  assign wrByte   = wrFire & wrMapped & axiReq.wstrb[0];
  assign wrData   = axiReq.wdata[7:0];

  assign statByte = {1'b0, fastDiv8_reg, dispBlk_reg, memReadyFlag,
                     regReadyFlag, mode_reg};
  assign rdByte   = (arIdx == `IDX_WAKE1) ? wakeEn_reg[0] :
                    (arIdx == `IDX_WAKE2) ? wakeEn_reg[1] :
                    (arIdx == `IDX_WAKE3) ? wakeEn_reg[2] :
                    (arIdx == `IDX_WAKE4) ? wakeEn_reg[3] :
                    (arIdx == `IDX_CTRL)  ? ctrl_reg :
                    (arIdx == `IDX_STAT)  ? statByte : 8'h00;

  assign axiRsp.awready = wrFire;
  assign axiRsp.wready  = wrFire;
  assign axiRsp.bvalid  = bvalid_reg;
  assign axiRsp.bresp   = bresp_reg;
  assign axiRsp.arready = rdFire;
  assign axiRsp.rvalid  = rvalid_reg;
  assign axiRsp.rdata   = rdata_reg;
  assign axiRsp.rresp   = rresp_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wrFire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axiReq.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (rdFire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rdMapped ? rdByte : 8'h00};
      rresp_reg  <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axiReq.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wakeup enable registers and event
  logic [7:0]  wakeMask [4];
  logic [31:0] srcVec;
  logic [31:0] enVec;
  logic [31:0] hitVec;
  logic [7:0]  grp4;

  assign wakeMask[0] = 8'hFF;
  assign wakeMask[1] = 8'hFF;
  assign wakeMask[2] = 8'hFF;
  assign wakeMask[3] = WAKE4_MASK; // R8

  assign grp4 = {
    1'b0,
    wakeSrc.cipher,                                          // R1
    wakeSrc.t5Capture | wakeSrc.t5Compare,                   // R2
    wakeSrc.t5Update | wakeSrc.t5Trigger | wakeSrc.t5Break,  // R3
    wakeSrc.ser3Rx | wakeSrc.ser3Tx,                         // R4
    wakeSrc.ser2Rx | wakeSrc.ser2Tx,                         // R5
    wakeSrc.sync2Rx | wakeSrc.sync2Tx,                       // R6
    wakeSrc.calendar | wakeSrc.clockFail                     // R7
  };
  assign srcVec = {grp4, wakeSrc.grp3, wakeSrc.grp2, wakeSrc.grp1};

  for (genvar r = 0; r < 4; r++) begin : g_wake
    assign enVec[r*8 +: 8] = wakeEn_reg[r];
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        wakeEn_reg[r] <= `WAKE_RST; // R8
      end else if (wrByte && awIdx == 6'(r)) begin
        wakeEn_reg[r] <= wrData & wakeMask[r]; // R8
      end
    end
  end

  for (genvar b = 0; b < 32; b++) begin : g_hit
    assign hitVec[b] = enVec[b] & srcVec[b]; // R23
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |hitVec; // R23
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `CTRL_RST;
    end else if (wrByte && awIdx == `IDX_CTRL) begin
      ctrl_reg <= {2'h0, wrData[5:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode sequencing
  logic regulator_off_bit;
  logic memPd;
  logic haltReq;
  logic busyAny;
  logic halted;
  logic haltWake;
  logic canHalt;
  logic haltTarget;

  assign regulator_off_bit   = ctrl_reg[`CTL_REGULATOR_OFF_BIT];
  assign memPd    = ctrl_reg[`CTL_MEMPD];
  assign haltReq  = haltInstr |
                    (intReturn & ctrl_reg[`CTL_ACTLVL]); // R19
  assign busyAny  = haltBusy.clkSwitch | haltBusy.memory |
                    haltBusy.calSwitch |
                    (haltBusy.beepSwitch & haltBusy.beepActHalt); // R15
  assign halted   = (mode_reg == low_power_wakeup_pkg::MODE_HALT) ||
                    (mode_reg == low_power_wakeup_pkg::MODE_ACT_HALT);
  assign haltWake = haltWakePin | haltWakeAlt; // R17
  assign canHalt  = (mode_reg == low_power_wakeup_pkg::MODE_RUN) ||
                    (mode_reg == low_power_wakeup_pkg::MODE_LP_RUN); // R22
  assign haltTarget = ctrl_reg[`CTL_ACTHALT];

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      low_power_wakeup_pkg::MODE_RUN: begin
        if (haltReq && !periphIrqPending) begin // R14
          mode_next = low_power_wakeup_pkg::MODE_HALT_PEND;
        end else if (regulator_off_bit) begin // R9
          mode_next = low_power_wakeup_pkg::MODE_LP_RUN;
        end
      end
      low_power_wakeup_pkg::MODE_LP_RUN: begin
        if (haltReq && !periphIrqPending) begin // R14
          mode_next = low_power_wakeup_pkg::MODE_HALT_PEND;
        end else if (waitEvtInstr) begin // R12
          mode_next = low_power_wakeup_pkg::MODE_LP_WAIT;
        end else if (!regulator_off_bit && mainRegReadyIn) begin // R10
          mode_next = low_power_wakeup_pkg::MODE_RUN;
        end
      end
      low_power_wakeup_pkg::MODE_LP_WAIT: begin
        if (wake_reg || extEvent) begin // R12
          mode_next = low_power_wakeup_pkg::MODE_LP_RUN;
        end
      end
      low_power_wakeup_pkg::MODE_HALT_PEND: begin
        if (!busyAny) begin // R15
          mode_next = haltTarget ?
                      low_power_wakeup_pkg::MODE_ACT_HALT :
                      low_power_wakeup_pkg::MODE_HALT;
        end
      end
      low_power_wakeup_pkg::MODE_HALT,
      low_power_wakeup_pkg::MODE_ACT_HALT: begin
        if (haltWake) begin // R17
          mode_next = regulator_off_bit ? low_power_wakeup_pkg::MODE_LP_RUN :
                               low_power_wakeup_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = low_power_wakeup_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= low_power_wakeup_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ignored_reg <= 1'b0;
      skipCtx_reg <= 1'b0;
    end else begin
      ignored_reg <= canHalt & haltReq & periphIrqPending; // R14
      skipCtx_reg <= canHalt & intReturn & ctrl_reg[`CTL_ACTLVL] &
                     ~periphIrqPending; // R19
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fastDiv8_reg <= 1'b0;
    end else if (halted && haltWake) begin
      fastDiv8_reg <= ctrl_reg[`CTL_FASTWAKE]; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display access block after halt wakeup
  logic calRise;
  assign calRise = calendarClk & ~calPrev_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      calPrev_reg <= 1'b0;
      dispBlk_reg <= 1'b0;
      dispCnt_reg <= 2'h0;
    end else begin
      calPrev_reg <= calendarClk;
      if (halted && haltWake) begin
        dispBlk_reg <= 1'b1; // R20
        dispCnt_reg <= 2'h0;
      end else if (dispBlk_reg && calRise) begin
        dispCnt_reg <= dispCnt_reg + 2'h1;
        if (dispCnt_reg + 2'h1 == `DISP_SYNC_CYCLES) begin
          dispBlk_reg <= 1'b0; // R20
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock and power controls
  logic actHalt;
  assign actHalt = (mode_reg == low_power_wakeup_pkg::MODE_ACT_HALT);

  assign sysClkRun  = ~halted | memWriteActive; // R13
  assign fastOscRun = ~halted | debugUsesFastOsc |
                      memWriteActive; // R13
  assign slowOscRun = ~halted | actHalt | debugUsesSlowOsc |
                      watchdogUsesSlowOsc; // R13 R21
  assign mainRegOn  = ~regulator_off_bit &
                      ~(halted & (ctrl_reg[`CTL_FASTHALT] |
                        ~(debugUsesFastOsc | memWriteActive))); // R16
  assign memPowerDown = memPd;
  assign regReadyFlag = ~regulator_off_bit & mainRegReadyIn; // R10
  assign memReadyFlag = ~memPd & memReadyIn; // R11

  assign wakeEvent          = wake_reg;
  assign haltIgnored        = ignored_reg;
  assign skipContextRestore = skipCtx_reg;
  assign mode               = mode_reg;
  assign restartFastDiv8    = fastDiv8_reg;
  assign displayBlock       = dispBlk_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_cipher_wake: assert property ( // R1
    wakeSrc.cipher && wakeEn_reg[3][`W4_CIPHER] |=> wakeEvent)
    else $error("cipher wake missing");
  a_t5cap_wake: assert property ( // R2
    wakeSrc.t5Compare && wakeEn_reg[3][`W4_T5CAP] |=> wakeEvent)
    else $error("timer5 compare wake missing");
  a_t5upd_wake: assert property ( // R3
    wakeSrc.t5Break && wakeEn_reg[3][`W4_T5UPD] |=> wakeEvent)
    else $error("timer5 break wake missing");
  a_ser3_wake: assert property ( // R4
    wakeSrc.ser3Tx && wakeEn_reg[3][`W4_SER3] |=> wakeEvent)
    else $error("serial3 wake missing");
  a_ser2_wake: assert property ( // R5
    wakeSrc.ser2Rx && wakeEn_reg[3][`W4_SER2] |=> wakeEvent)
    else $error("serial2 wake missing");
  a_sync2_wake: assert property ( // R6
    wakeSrc.sync2Rx && wakeEn_reg[3][`W4_SYNC2] |=> wakeEvent)
    else $error("sync serial2 wake missing");
  a_cal_wake: assert property ( // R7
    wakeSrc.clockFail && wakeEn_reg[3][`W4_CAL] |=> wakeEvent)
    else $error("calendar wake missing");
  a_no_stray_wake: assert property ( // R23
    wakeEvent |-> $past(|(enVec & srcVec)))
    else $error("wake without enabled source");
  a_wake4_rsvd: assert property ( // R8
    (wakeEn_reg[3] & ~WAKE4_MASK) == 8'h00)
    else $error("reserved enable bit set");

  sequence s_lp_waiting;
    mode_reg == low_power_wakeup_pkg::MODE_LP_WAIT && extEvent;
  endsequence
  a_lp_wait_exit: assert property ( // R12
    s_lp_waiting |=> mode_reg == low_power_wakeup_pkg::MODE_LP_RUN)
    else $error("low-power wait did not end");

  sequence s_halt_refused;
    mode_reg == low_power_wakeup_pkg::MODE_RUN && haltInstr &&
    periphIrqPending && !regulator_off_bit;
  endsequence
  a_halt_refused: assert property ( // R14
    s_halt_refused |=> haltIgnored &&
      mode_reg == low_power_wakeup_pkg::MODE_RUN)
    else $error("halt taken with pending interrupt");

  a_busy_hold: assert property ( // R15
    mode_reg == low_power_wakeup_pkg::MODE_HALT_PEND && busyAny |=>
      mode_reg == low_power_wakeup_pkg::MODE_HALT_PEND)
    else $error("halt entered while busy");
  a_fast_halt_reg: assert property ( // R16
    halted && ctrl_reg[`CTL_FASTHALT] |-> !mainRegOn)
    else $error("regulator on in fast halt");
  a_restart_clk: assert property ( // R18
    halted && haltWake |=>
      restartFastDiv8 == $past(ctrl_reg[`CTL_FASTWAKE]) && !halted)
    else $error("restart clock select wrong");
  a_disp_block: assert property ( // R20
    halted && haltWake |=> displayBlock)
    else $error("display not blocked after wake");
  a_disp_hold: assert property ( // R20
    displayBlock && !(calRise && dispCnt_reg == 2'h1) |=> displayBlock)
    else $error("display block ended early");
  a_act_halt_osc: assert property ( // R21
    actHalt |-> slowOscRun && !sysClkRun == !memWriteActive)
    else $error("active-halt oscillator wrong");

endmodule // low_power_wakeup_control

// [cpu_side_model.sv]
`timescale 1ns/1ps
// cpu pulses and slow calendar clock, idle low between uses
module cpu_side_model (
  input  wire logic core_clk,
  output logic      waitEvtInstr,
  output logic      haltInstr,
  output logic      intReturn,
  output logic      calendarClk
);
  initial begin
    waitEvtInstr = 1'b0;
    haltInstr    = 1'b0;
    intReturn    = 1'b0;
    calendarClk  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle instruction pulse: 0 wait, 1 halt, 2 interrupt return
  task automatic pulse(input int k);
    @(posedge core_clk);
    waitEvtInstr <= (k == 0);
    haltInstr    <= (k == 1);
    intReturn    <= (k == 2);
    @(posedge core_clk);
    waitEvtInstr <= 1'b0;
    haltInstr    <= 1'b0;
    intReturn    <= 1'b0;
  endtask
  // one calendar clock period, then stands still
  task automatic cal();
    @(posedge core_clk);
    calendarClk <= 1'b1;
    repeat (3) @(posedge core_clk);
    calendarClk <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // cpu_side_model

// [testbench.sv]
`timescale 1ns/1ps
`include "low_power_wakeup_cfg.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rstn     = 1'b0;
  low_power_wakeup_pkg::axil_req_s  axiReq   = '0;
  low_power_wakeup_pkg::axil_rsp_s  axiRsp;
  low_power_wakeup_pkg::wake_src_s  wakeSrc  = '0;
  low_power_wakeup_pkg::halt_busy_s haltBusy = '0;
  logic periphIrqPending = 1'b0, extEvent = 1'b0, haltWakePin = 1'b0;
  logic haltWakeAlt = 1'b0, mainRegReadyIn = 1'b1, memReadyIn = 1'b1;
  logic debugUsesFastOsc = 1'b0, debugUsesSlowOsc = 1'b0;
  logic watchdogUsesSlowOsc = 1'b0, memWriteActive = 1'b0;
  logic waitEvtInstr, haltInstr, intReturn, calendarClk;
  logic wakeEvent, haltIgnored, skipContextRestore, sysClkRun, fastOscRun;
  logic slowOscRun, mainRegOn, memPowerDown, regReadyFlag, memReadyFlag;
  logic restartFastDiv8, displayBlock;
  logic [2:0]  mode;
  logic [33:0] expQ[$];
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  always #10 core_clk = ~core_clk;

  low_power_wakeup_control uut (.core_clk, .rstn, .axiReq, .axiRsp,
    .wakeSrc, .haltBusy, .waitEvtInstr, .haltInstr, .intReturn,
    .periphIrqPending, .extEvent, .haltWakePin, .haltWakeAlt,
    .mainRegReadyIn, .memReadyIn, .debugUsesFastOsc, .debugUsesSlowOsc,
    .watchdogUsesSlowOsc, .memWriteActive, .calendarClk, .wakeEvent,
    .haltIgnored, .skipContextRestore, .mode, .sysClkRun, .fastOscRun,
    .slowOscRun, .mainRegOn, .memPowerDown, .regReadyFlag, .memReadyFlag,
    .restartFastDiv8, .displayBlock);
  cpu_side_model cpu (.core_clk, .waitEvtInstr, .haltInstr, .intReturn,
    .calendarClk);
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (e !== g) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic cb(input logic e, input logic g);
    cmp({33'h0, e}, {33'h0, g});
  endtask
  task automatic cm(input logic [2:0] e);
    cmp({31'h0, e}, {31'h0, mode});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bus master tasks, read results checked by the monitor below
  task automatic wr(input logic [5:0] i, input logic [7:0] d,
                    input logic [1:0] r);
    @(posedge core_clk);
    axiReq.awaddr  <= {i, 2'b00};
    axiReq.wdata   <= {24'h0, d};
    axiReq.wstrb   <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    do @(posedge core_clk); while (!(axiRsp.awready && axiRsp.wready));
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid  <= 1'b0;
    do @(posedge core_clk); while (!axiRsp.bvalid);
    axiReq.bready <= 1'b0;
    cmp({32'h0, r}, {32'h0, axiRsp.bresp});
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] d,
                    input logic [1:0] r);
    expQ.push_back({r, d});
    @(posedge core_clk);
    axiReq.araddr  <= {i, 2'b00};
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    do @(posedge core_clk); while (!axiRsp.arready);
    axiReq.arvalid <= 1'b0;
    do @(posedge core_clk); while (!axiRsp.rvalid);
    axiReq.rready <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (axiRsp.rvalid === 1'b1 && axiReq.rready === 1'b1) begin
      cmp(expQ.pop_front(), {axiRsp.rresp, axiRsp.rdata});
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end
  // one source of the group behind each bit of the fourth register
  function automatic low_power_wakeup_pkg::wake_src_s src(input int b);
    low_power_wakeup_pkg::wake_src_s s;
    s = '0;
    case (b)
      6: s.cipher = 1'b1;
      5: s.t5Compare = 1'b1;
      4: s.t5Trigger = 1'b1;
      3: s.ser3Rx = 1'b1;
      2: s.ser2Tx = 1'b1;
      1: s.sync2Rx = 1'b1;
      default: s.calendar = 1'b1;
    endcase
    return s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int         b;
    logic [7:0] v;
    void'($urandom(2095));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1);
    for (b = 0; b < 5; b++) rd(6'(b), 32'h0, `RESP_OKAY);
    rd(6'h06, 32'h0, `RESP_SLVERR);
    wr(6'h07, 8'hFF, `RESP_SLVERR);
    wr(`IDX_WAKE4, 8'hFF, `RESP_OKAY);
    rd(`IDX_WAKE4, 32'h7F, `RESP_OKAY);
    v = 8'($urandom());
    wr(`IDX_WAKE1, v, `RESP_OKAY);
    rd(`IDX_WAKE1, {24'h0, v}, `RESP_OKAY);
    wr(`IDX_WAKE1, 8'h00, `RESP_OKAY);
    done("registers");
    for (b = 0; b < 7; b++) begin
      wakeSrc <= src(b);
      wr(`IDX_WAKE4, 8'(1 << b), `RESP_OKAY);
      cyc(2);
      cb(1'b1, wakeEvent);
      wr(`IDX_WAKE4, 8'h7F & ~8'(1 << b), `RESP_OKAY);
      cyc(2);
      cb(1'b0, wakeEvent);
    end
    wakeSrc <= '0;
    v = 8'($urandom()) | 8'h01;
    wr(`IDX_WAKE2, v, `RESP_OKAY);
    wakeSrc.grp2 <= ~v;
    cyc(2);
    cb(1'b0, wakeEvent);
    wakeSrc.grp2 <= 8'h01;
    cyc(2);
    cb(1'b1, wakeEvent);
    wakeSrc.grp2 <= 8'h00;
    wr(`IDX_WAKE2, 8'h00, `RESP_OKAY);
    done("wakeup");
    wr(`IDX_CTRL, 8'h02, `RESP_OKAY);
    cyc(4);
    wr(`IDX_CTRL, 8'h03, `RESP_OKAY);
    cyc(1);
    cm(low_power_wakeup_pkg::MODE_LP_RUN);
    cb(1'b0, regReadyFlag);
    cb(1'b1, memPowerDown);
    cb(1'b0, memReadyFlag);
    cpu.pulse(0);
    cyc(3);
    cm(low_power_wakeup_pkg::MODE_LP_WAIT);
    extEvent <= 1'b1;
    cyc(1);
    cm(low_power_wakeup_pkg::MODE_LP_RUN);
    extEvent       <= 1'b0;
    mainRegReadyIn <= 1'b0;
    wr(`IDX_CTRL, 8'h02, `RESP_OKAY);
    cyc(2);
    cb(1'b0, regReadyFlag);
    cm(low_power_wakeup_pkg::MODE_LP_RUN);
    mainRegReadyIn <= 1'b1;
    cyc(2);
    cb(1'b1, regReadyFlag);
    cm(low_power_wakeup_pkg::MODE_RUN);
    wr(`IDX_CTRL, 8'h00, `RESP_OKAY);
    cyc(1);
    cb(1'b1, memReadyFlag);
    done("low power run");
    periphIrqPending <= 1'b1;
    cpu.pulse(1);
    cyc(0);
    cb(1'b1, haltIgnored);
    cm(low_power_wakeup_pkg::MODE_RUN);
    periphIrqPending    <= 1'b0;
    haltBusy.memory     <= 1'b1;
    memWriteActive      <= 1'b1;
    debugUsesFastOsc    <= 1'b1;
    watchdogUsesSlowOsc <= 1'b1;
    wr(`IDX_CTRL, 8'h0C, `RESP_OKAY);
    cpu.pulse(1);
    cyc(4);
    cm(low_power_wakeup_pkg::MODE_HALT_PEND);
    cb(1'b1, mainRegOn);
    haltBusy.memory     <= 1'b0;
    haltBusy.beepSwitch <= 1'b1;
    cyc(2);
    cm(low_power_wakeup_pkg::MODE_HALT);
    cb(1'b1, sysClkRun);
    cb(1'b1, fastOscRun);
    cb(1'b1, slowOscRun);
    cb(1'b0, mainRegOn);
    memWriteActive      <= 1'b0;
    debugUsesFastOsc    <= 1'b0;
    watchdogUsesSlowOsc <= 1'b0;
    cyc(1);
    cb(1'b0, slowOscRun);
    cb(1'b0, sysClkRun);
    cb(1'b0, fastOscRun);
    haltWakePin <= 1'b1;
    cyc(1);
    haltWakePin <= 1'b0;
    cm(low_power_wakeup_pkg::MODE_RUN);
    cb(1'b1, restartFastDiv8);
    cb(1'b1, displayBlock);
    cpu.cal();
    cyc(0);
    cb(1'b1, displayBlock);
    cpu.cal();
    cyc(0);
    cb(1'b0, displayBlock);
    done("halt");
    haltBusy <= '0;
    wr(`IDX_CTRL, 8'h30, `RESP_OKAY);
    cpu.pulse(2);
    cyc(0);
    cb(1'b1, skipContextRestore);
    cm(low_power_wakeup_pkg::MODE_HALT_PEND);
    cyc(1);
    cm(low_power_wakeup_pkg::MODE_ACT_HALT);
    cb(1'b1, slowOscRun);
    cb(1'b0, fastOscRun);
    cb(1'b0, sysClkRun);
    haltWakeAlt <= 1'b1;
    cyc(1);
    haltWakeAlt <= 1'b0;
    cm(low_power_wakeup_pkg::MODE_RUN);
    cb(1'b0, restartFastDiv8);
    done("active halt");
    close_out();
  end
endmodule // testbench
